// ---- flash_row_programmer.sv ----
// Software end: steps through one row program sequence with timed waits.
module flash_row_programmer
  import flash_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Controller side
  flash_bus_if.host bus,
  // User side
  input wire logic i_start,
  input wire logic [15:0] i_row_addr,
  input wire logic [5:0] i_count,
  input wire logic [7:0] i_byte,
  input wire logic i_monitor_fail,
  input wire logic i_enter_low_power,
  output logic o_busy,
  output logic o_done,
  output logic o_refused,
  output logic [4:0] o_byte_idx,
  output logic [7:0] o_protect_bits
);
  typedef enum logic [3:0] {
    H_IDLE = 4'h0, H_SEL = 4'h1, H_RDP = 4'h2, H_LATCH = 4'h3, H_NVS = 4'h4,
    H_SETHV = 4'h5, H_CHECK = 4'h6, H_PGS = 4'h7, H_WRB = 4'h8, H_PROG = 4'h9,
    H_CLRP = 4'ha, H_NVH = 4'hb, H_CLRHV = 4'hc, H_BCV = 4'hd
  } host_e;

  typedef struct packed {
    host_e st;
    logic req;
    logic we;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic ctl_wr;
    logic [3:0] ctl;
    logic [15:0] row;
    logic [5:0] left;
    logic [4:0] idx;
    logic busy;
    logic done;
    logic refused;
    logic [7:0] prot;
    logic lowp;
    logic tload;
    logic [TIMER_W-1:0] tcyc;
  } host_s;
  host_s q, d;
  logic t_run;
  logic t_wait;

  flash_delay_timer #(.W(TIMER_W)) u_timer (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_load(q.tload),
    .i_cycles(q.tcyc),
    .o_running(t_run)
  );

  always_comb begin
    d = q;
    d.ctl_wr = 1'b0;
    d.tload = 1'b0;
    d.done = 1'b0;
    d.lowp = i_enter_low_power;
    t_wait = q.tload || t_run;
    unique case (q.st)
      H_IDLE: if (i_start) begin
        d.row = i_row_addr;
        d.left = i_count;
        d.idx = '0;
        d.refused = 1'b0;
        d.busy = 1'b1;
        d.st = H_SEL;
      end
      H_SEL: begin
        d.ctl_wr = 1'b1;
        d.ctl = 4'h1 << CTL_PGM;
        d.we = 1'b0;
        d.addr = PROTECT_ADDR;
        d.st = H_RDP;
      end
      // The read trails the select write by a cycle, or the controller takes it before the select.
      H_RDP: if (!q.req) begin
        d.req = 1'b1;
      end else if (bus.mem_ack) begin
        d.prot = bus.mem_rdata;
        d.we = 1'b1;
        d.addr = i_monitor_fail ? PROTECT_ADDR : {q.row[15:ROW_LSB], 5'h00};
        d.st = H_LATCH;
      end
      H_LATCH: if (bus.mem_ack) begin
        d.req = 1'b0;
        d.tload = 1'b1;
        d.tcyc = TIMER_W'(NVS_CYC);
        d.st = H_NVS;
      end
      H_NVS: if (!t_wait) begin
        d.st = H_SETHV;
      end
      H_SETHV: begin
        d.ctl_wr = 1'b1;
        d.ctl = (4'h1 << CTL_PGM) | (4'h1 << CTL_HIGH_VOLTAGE_ENABLE);
        d.st = H_CHECK;
      end
      H_CHECK: if (!q.ctl_wr) begin
        d.refused = !bus.ctl_status[CTL_HIGH_VOLTAGE_ENABLE];
        d.tload = 1'b1;
        d.tcyc = TIMER_W'(PGS_CYC);
        d.st = bus.ctl_status[CTL_HIGH_VOLTAGE_ENABLE] ? H_PGS : H_CLRP;
      end
      H_PGS: if (!t_wait) begin
        d.st = H_WRB;
      end
      H_WRB: if (q.left == '0) begin
        d.st = H_CLRP;
      end else if (!q.req) begin
        d.addr = {q.row[15:ROW_LSB], q.idx};
        d.wdata = i_byte;
        d.req = ({q.row[15:ROW_LSB], q.idx} != WATCHDOG_ADDR);
        d.st = d.req ? H_WRB : H_PROG;
        d.tload = !d.req;
        d.tcyc = TIMER_W'(PROG_CYC);
      end else if (bus.mem_ack) begin
        d.req = 1'b0;
        d.tload = 1'b1;
        d.tcyc = TIMER_W'(PROG_CYC);
        d.st = H_PROG;
      end
      H_PROG: if (!t_wait) begin
        d.left = q.left - 1'b1;
        d.idx = q.idx + 1'b1;
        d.st = H_WRB;
      end
      H_CLRP: begin
        d.ctl_wr = 1'b1;
        d.ctl = 4'h1 << CTL_HIGH_VOLTAGE_ENABLE;
        d.tload = 1'b1;
        d.tcyc = TIMER_W'(NVH_CYC);
        d.st = H_NVH;
      end
      H_NVH: if (!t_wait) begin
        d.st = H_CLRHV;
      end
      H_CLRHV: begin
        d.ctl_wr = 1'b1;
        d.ctl = 4'h0;
        d.tload = 1'b1;
        d.tcyc = TIMER_W'(BCV_CYC);
        d.st = H_BCV;
      end
      H_BCV: if (!t_wait) begin
        d.busy = 1'b0;
        d.done = 1'b1;
        d.st = H_IDLE;
      end
      default: d.st = H_IDLE;
    endcase
    // Entering a low power mode mid-sequence loses the row, so it is reported as refused.
    if (i_enter_low_power && q.busy) begin
      d.req = 1'b0;
      d.ctl_wr = 1'b0;
      d.busy = 1'b0;
      d.done = 1'b1;
      d.refused = 1'b1;
      d.st = H_IDLE;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign bus.ctl_wr = q.ctl_wr;
  assign bus.ctl_wdata = q.ctl;
  assign bus.mem_req = q.req;
  assign bus.mem_we = q.we;
  assign bus.mem_addr = q.addr;
  assign bus.mem_wdata = q.wdata;
  assign bus.low_power = q.lowp;
  assign o_busy = q.busy;
  assign o_done = q.done;
  assign o_refused = q.refused;
  assign o_byte_idx = q.idx;
  assign o_protect_bits = q.prot;
endmodule : flash_row_programmer

// ---- flash_pkg.sv ----
// Shared constants and types for the flash program and protect controller.
package flash_pkg;
  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 100;
  localparam int T_NVS_NS = 10000;
  localparam int T_PGS_NS = 5000;
  localparam int BYTE_PROGRAM_TIME_NS = 30000;
  localparam int NONVOLATILE_HOLD_TIME_NS = 5000;
  localparam int READ_RECOVERY_TIME_NS = 1000;
  localparam int NVS_CYC = (T_NVS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PGS_CYC = (T_PGS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PROG_CYC = (BYTE_PROGRAM_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int NVH_CYC = (NONVOLATILE_HOLD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BCV_CYC = (READ_RECOVERY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMER_W = 9;
  // ****************************************************************
  // Control bits and addresses
  // ****************************************************************
  localparam int CTL_PGM = 0;
  localparam int CTL_ERASE = 1;
  localparam int CTL_MASS = 2;
  localparam int CTL_HIGH_VOLTAGE_ENABLE = 3;
  localparam int CTL_W = 4;
  localparam logic [15:0] PROTECT_ADDR = 16'hffb0;
  localparam logic [15:0] WATCHDOG_ADDR = 16'hffff;
  localparam logic [7:0] PROTECT_NONE = 8'hff;
  localparam logic [1:0] START_HI = 2'b11;
  localparam logic [5:0] START_LO = 6'h00;
  localparam int ROW_LSB = 5;
  localparam int PAGE_LSB = 6;
  typedef enum logic [1:0] {
    SQ_SEL = 2'b00,
    SQ_PRD = 2'b01,
    SQ_LATCH = 2'b10,
    SQ_HV = 2'b11
  } seq_e;
endpackage : flash_pkg

// ---- flash_bus_if.sv ----
// Interface joining the sequencing software end and the flash controller.
interface flash_bus_if;
  logic ctl_wr;
  logic [3:0] ctl_wdata;
  logic [3:0] ctl_status;
  logic mem_req;
  logic mem_we;
  logic [15:0] mem_addr;
  logic [7:0] mem_wdata;
  logic mem_ack;
  logic [7:0] mem_rdata;
  logic low_power;
  modport dev (
    input ctl_wr, ctl_wdata, mem_req, mem_we, mem_addr, mem_wdata, low_power,
    output ctl_status, mem_ack, mem_rdata
  );
  modport host (
    output ctl_wr, ctl_wdata, mem_req, mem_we, mem_addr, mem_wdata, low_power,
    input ctl_status, mem_ack, mem_rdata
  );
endinterface : flash_bus_if

// ---- flash_delay_timer.sv ----
// Down counter that measures minimum waits in bus clock cycles.
module flash_delay_timer
  import flash_pkg::*;
#(
  parameter int W = TIMER_W
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Load and status
  input wire logic i_load,
  input wire logic [W-1:0] i_cycles,
  output logic o_running
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic run;
  } timer_s;
  timer_s q, d;

  always_comb begin
    d = q;
    if (i_load) begin
      d.cnt = i_cycles;
    end else if (q.cnt != '0) begin
      d.cnt = q.cnt - 1'b1;
    end
    d.run = (d.cnt != '0);
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_running = q.run;
endmodule : flash_delay_timer

// ---- flash_program_protect_ctrl.sv ----
// Flash controller end: select interlock, protect range, high voltage gate, standby.
module flash_program_protect_ctrl
  import flash_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Software side
  flash_bus_if.dev bus,
  // Device conditions
  input wire logic i_test_high_voltage,
  input wire logic [7:0] i_nv_protect,
  // Flash array
  input wire logic [7:0] i_arr_rdata,
  output logic o_arr_rd,
  output logic o_arr_we,
  output logic [15:0] o_arr_addr,
  output logic [7:0] o_arr_wdata,
  output logic o_arr_prog,
  output logic o_arr_erase,
  output logic o_arr_mass,
  output logic o_arr_hv,
  output logic [7:0] o_protect_bits
);
  // ****************************************************************
  // State
  // ****************************************************************
  localparam int REC_W = $clog2(BCV_CYC + 1);
  localparam logic [REC_W-1:0] REC_LOAD = REC_W'(BCV_CYC);

  typedef struct packed {
    logic program_select;
    logic erase;
    logic mass;
    logic high_voltage_enable;
    seq_e seq;
    logic loaded;
    logic [7:0] prot;
    logic [15:0] tgt;
    logic tgt_blk;
    logic [REC_W-1:0] rec;
    logic pend;
    logic ack;
    logic [7:0] rdata;
    logic arr_rd;
    logic arr_we;
    logic [15:0] arr_addr;
    logic [7:0] arr_wdata;
  } ctrl_s;
  ctrl_s q, d;

  // ****************************************************************
  // Protection check
  // ****************************************************************
  function automatic logic is_blocked(input logic [15:0] a, input logic [7:0] prot, input logic tv);
    logic [15:0] start;
    start = {START_HI, prot, START_LO};
    // The test voltage lifts the range lock, though not the mass erase lock, so a locked part can still be recovered.
    is_blocked = !tv && (prot != PROTECT_NONE) && ({a[15:PAGE_LSB], 6'h00} >= start);
  endfunction : is_blocked

  logic hv_ok;
  logic [3:0] wd;

  // ****************************************************************
  // Access decode
  // ****************************************************************
  logic mem_take;
  logic at_protect;
  logic row_hit;
  logic prog_ok;
  assign mem_take = bus.mem_req && !q.ack && !q.pend && (q.rec == '0) && q.loaded;
  assign at_protect = (bus.mem_addr == PROTECT_ADDR);
  assign row_hit = (bus.mem_addr[15:ROW_LSB] == q.tgt[15:ROW_LSB]);
  // The stored byte also needs test voltage, so a stray row write cannot lock the part.
  assign prog_ok = (q.seq == SQ_HV) && q.program_select && row_hit &&
                   !is_blocked(bus.mem_addr, q.prot, i_test_high_voltage) &&
                   (!at_protect || i_test_high_voltage);

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    d = q;
    wd = bus.ctl_wdata;
    d.ack = 1'b0;
    d.arr_rd = 1'b0;
    d.arr_we = 1'b0;
    hv_ok = (q.program_select || q.erase) && (q.seq == SQ_LATCH) && !q.tgt_blk && q.loaded;
    if (!q.loaded) begin
      d.prot = i_nv_protect;
      d.loaded = 1'b1;
    end
    if (q.rec != '0) begin
      d.rec = q.rec - 1'b1;
    end
    if (q.pend) begin
      d.pend = 1'b0;
      d.ack = 1'b1;
      d.rdata = (q.arr_addr == PROTECT_ADDR) ? q.prot : i_arr_rdata;
    end
    if (bus.ctl_wr) begin
      if (!(wd[CTL_PGM] && wd[CTL_ERASE])) begin
        d.program_select = wd[CTL_PGM] && !q.erase;
        d.erase = wd[CTL_ERASE] && !q.program_select;
      end
      d.mass = wd[CTL_MASS];
      if (wd[CTL_HIGH_VOLTAGE_ENABLE] && !q.high_voltage_enable && hv_ok) begin
        d.high_voltage_enable = 1'b1;
        d.seq = SQ_HV;
        if (q.erase && (q.mass || q.tgt[15:PAGE_LSB] == PROTECT_ADDR[15:PAGE_LSB])) begin
          d.prot = PROTECT_NONE;
        end
      end else if (!wd[CTL_HIGH_VOLTAGE_ENABLE] && q.high_voltage_enable) begin
        d.high_voltage_enable = 1'b0;
        d.seq = SQ_SEL;
        d.rec = REC_LOAD;
      end
    end
    if (mem_take) begin
      d.arr_addr = bus.mem_addr;
      if (!bus.mem_we) begin
        d.arr_rd = 1'b1;
        d.pend = 1'b1;
        if (at_protect && (q.seq == SQ_SEL) && (q.program_select || q.erase)) begin
          d.seq = SQ_PRD;
        end
      end else begin
        d.ack = 1'b1;
        if (q.seq == SQ_PRD) begin
          d.seq = SQ_LATCH;
          d.tgt = bus.mem_addr;
          d.tgt_blk = is_blocked(bus.mem_addr, q.prot, i_test_high_voltage) ||
                      (q.erase && q.mass && (q.prot != PROTECT_NONE));
        end else if (prog_ok) begin
          d.arr_we = 1'b1;
          d.arr_wdata = bus.mem_wdata;
          if (at_protect) begin
            d.prot = q.prot & bus.mem_wdata;
          end
        end
      end
    end
    if (!d.program_select && !d.erase && !d.high_voltage_enable) begin
      d.seq = SQ_SEL;
    end
    // Aborting leaves the target bytes in an undefined state; software must redo them.
    if (bus.low_power && (q.program_select || q.erase || q.mass || q.high_voltage_enable)) begin
      d.program_select = 1'b0;
      d.erase = 1'b0;
      d.mass = 1'b0;
      d.high_voltage_enable = 1'b0;
      d.arr_we = 1'b0;
      d.seq = SQ_SEL;
    end
  end

  // ****************************************************************
  // Register
  // ****************************************************************
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      q <= '0;
      q.prot <= PROTECT_NONE;
    end else begin
      q <= d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign bus.ctl_status = {q.high_voltage_enable, q.mass, q.erase, q.program_select};
  assign bus.mem_ack = q.ack;
  assign bus.mem_rdata = q.rdata;
  assign o_arr_rd = q.arr_rd;
  assign o_arr_we = q.arr_we;
  assign o_arr_addr = q.arr_addr;
  assign o_arr_wdata = q.arr_wdata;
  assign o_arr_prog = q.program_select;
  assign o_arr_erase = q.erase;
  assign o_arr_mass = q.mass;
  assign o_arr_hv = q.high_voltage_enable;
  assign o_protect_bits = q.prot;
endmodule : flash_program_protect_ctrl

// ---- flash_ctrl_monitor.sv ----
// Checker on the bus joining the sequencing end and the flash controller.
module flash_ctrl_monitor (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Bus signals
  input wire logic ctl_wr,
  input wire logic [3:0] ctl_wdata,
  input wire logic [3:0] ctl_status,
  input wire logic mem_req,
  input wire logic mem_ack,
  input wire logic [7:0] mem_rdata,
  input wire logic low_power
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  // Reads must not be answered while the array recovers from high voltage.
  sequence s_quiet;
    !mem_ack [*8];
  endsequence
  property p_select_interlock;
    !(ctl_status[0] && ctl_status[1]);
  endproperty
  property p_hv_needs_select;
    $rose(ctl_status[3]) |-> $past(ctl_wr) && ($past(ctl_status[0]) || $past(ctl_status[1]));
  endproperty
  property p_select_answer;
    ctl_wr && ctl_wdata == 4'h1 && !ctl_status[1] && !low_power |=> ctl_status == 4'h1;
  endproperty
  property p_clear_answer;
    ctl_wr && ctl_wdata == 4'h0 |=> ctl_status == 4'h0;
  endproperty
  property p_low_power_abort;
    low_power && ctl_status != 4'h0 |=> ctl_status == 4'h0;
  endproperty
  property p_standby_hold;
    low_power && ctl_status == 4'h0 && !ctl_wr |=> ctl_status == 4'h0;
  endproperty
  property p_read_recovery;
    $fell(ctl_status[3]) |-> s_quiet;
  endproperty
  property p_ack_pulse;
    mem_ack |=> !mem_ack;
  endproperty
  property p_ack_needs_req;
    mem_ack |-> mem_req;
  endproperty
  property p_rdata_hold;
    $changed(mem_rdata) |-> mem_ack;
  endproperty
  property p_req_answered;
    mem_req && !mem_ack |-> ##[1:16] mem_ack;
  endproperty
  a_select_interlock: assert property (p_select_interlock) else $error("both selects set");
  a_hv_needs_select: assert property (p_hv_needs_select) else $error("voltage set without select");
  a_select_answer: assert property (p_select_answer) else $error("select write not applied");
  a_clear_answer: assert property (p_clear_answer) else $error("clear write not applied");
  a_low_power_abort: assert property (p_low_power_abort) else $error("low power did not abort");
  a_standby_hold: assert property (p_standby_hold) else $error("control set in standby");
  a_read_recovery: assert property (p_read_recovery) else $error("access during recovery");
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  a_ack_needs_req: assert property (p_ack_needs_req) else $error("ack without request");
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data changed without ack");
  a_req_answered: assert property (p_req_answered) else $error("request not answered");
endmodule : flash_ctrl_monitor

// ---- flash_program_protect_ctrl_tb.sv ----
// Testbench joining the row programmer and the flash controller end to end.
`define CHECK(got, exp, msg) begin n_checks++; if ((got) !== (exp)) begin mismatches++; \
  $display("[FAIL] %0t %s", $time, msg); end end
module flash_program_protect_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic tv, start, mfail, lp;
  logic [7:0] nv, arr_rdata, byte_d, dev_prot, host_prot, arr_wdata;
  logic [15:0] row, arr_addr;
  logic [5:0] cnt;
  logic [4:0] idx;
  logic arr_rd, arr_we, arr_prog, arr_erase, arr_mass, arr_hv, busy, done, refused;
  int mismatches = 0;
  int n_checks = 0;
  int we_cnt = 0;
  int i;
  always #50 i_clk = ~i_clk;
  // The array answers with a pattern that follows the address, so a stale read shows.
  assign arr_rdata = ~arr_addr[7:0];
  assign byte_d = 8'hc0 | {3'h0, idx};
  flash_bus_if flash_bus_if_i ();
  flash_program_protect_ctrl flash_program_protect_ctrl_i (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .bus(flash_bus_if_i), .i_test_high_voltage(tv), .i_nv_protect(nv), .i_arr_rdata(arr_rdata),
    .o_arr_rd(arr_rd), .o_arr_we(arr_we), .o_arr_addr(arr_addr), .o_arr_wdata(arr_wdata),
    .o_arr_prog(arr_prog), .o_arr_erase(arr_erase), .o_arr_mass(arr_mass), .o_arr_hv(arr_hv),
    .o_protect_bits(dev_prot));
  flash_row_programmer flash_row_programmer_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .bus(flash_bus_if_i),
    .i_start(start), .i_row_addr(row), .i_count(cnt), .i_byte(byte_d), .i_monitor_fail(mfail),
    .i_enter_low_power(lp), .o_busy(busy), .o_done(done), .o_refused(refused), .o_byte_idx(idx),
    .o_protect_bits(host_prot));
  flash_ctrl_monitor flash_ctrl_monitor_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .ctl_wr(flash_bus_if_i.ctl_wr),
    .ctl_wdata(flash_bus_if_i.ctl_wdata), .ctl_status(flash_bus_if_i.ctl_status),
    .mem_req(flash_bus_if_i.mem_req), .mem_ack(flash_bus_if_i.mem_ack),
    .mem_rdata(flash_bus_if_i.mem_rdata), .low_power(flash_bus_if_i.low_power));
  // ****************************************************************
  // Tasks
  // ****************************************************************
  always @(posedge i_clk) begin
    if (arr_we === 1'b1) begin
      we_cnt++;
      `CHECK(arr_addr[15:5], row[15:5], "program write outside row")
      `CHECK(arr_wdata, 8'hc0 | 8'(arr_addr[4:0]), "program write data")
    end
    if (arr_rd === 1'b1) begin
      `CHECK(arr_addr, flash_pkg::PROTECT_ADDR, "array read address")
    end
  end
  task wrap_up;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : wrap_up
  task do_reset(input logic [7:0] v, input logic t, input logic m);
    @(negedge i_clk);
    i_rst_n = 1'b0;
    nv = v;
    tv = t;
    mfail = m;
    repeat (2) @(negedge i_clk);
    i_rst_n = 1'b1;
    repeat (3) @(negedge i_clk);
  endtask : do_reset
  // A negative expected count skips the write count where the latch target is not the row.
  task run_row(input logic [15:0] a, input logic [5:0] c, input logic ref_e, input int we_e);
    int k;
    row = a;
    cnt = c;
    we_cnt = 0;
    start = 1'b1;
    @(negedge i_clk);
    start = 1'b0;
    for (k = 0; k < 12000 && done !== 1'b1; k++) begin
      @(negedge i_clk);
    end
    if (done !== 1'b1) begin
      mismatches++;
      $display("[FAIL] %0t %s", $time, "row sequence did not finish");
      wrap_up();
    end
    `CHECK(refused, ref_e, "refusal flag")
    `CHECK(busy, 1'b0, "busy after done")
    if (we_e >= 0) begin
      `CHECK(we_cnt, we_e, "program write count")
    end
    $display("row test at %h done", a);
  endtask : run_row
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    tv = 1'b0;
    start = 1'b0;
    mfail = 1'b0;
    lp = 1'b0;
    nv = 8'hff;
    row = 16'h0000;
    cnt = 6'd0;
    do_reset(8'hff, 1'b0, 1'b0);
    run_row(16'hf800, 6'd2, 1'b0, 2);
    `CHECK(host_prot, 8'hff, "protect byte read")
    run_row(16'hffe0, 6'd32, 1'b0, 31);
    tv = 1'b1;
    run_row(16'hffa0, 6'd17, 1'b0, 17);
    `CHECK(dev_prot, 8'hd0, "protect byte programmed")
    tv = 1'b0;
    run_row(16'hf7e0, 6'd1, 1'b1, 0);
    run_row(16'hf3e0, 6'd1, 1'b0, 1);
    do_reset(8'he0, 1'b0, 1'b1);
    run_row(16'hf7e0, 6'd1, 1'b1, 0);
    `CHECK(host_prot, 8'he0, "stored protect byte read")
    mfail = 1'b0;
    run_row(16'hf800, 6'd1, 1'b1, 0);
    for (i = 0; i < 2; i++) begin
      do_reset((i == 0) ? 8'h00 : 8'hb8, 1'b0, 1'b0);
      run_row(16'hee00, 6'd1, 1'b1, 0);
    end
    do_reset(8'hff, 1'b0, 1'b0);
    run_row(16'hffa0, 6'd17, 1'b0, 16);
    `CHECK(dev_prot, 8'hff, "protect byte kept without test voltage")
    row = 16'hf800;
    cnt = 6'd2;
    start = 1'b1;
    @(negedge i_clk);
    start = 1'b0;
    repeat (200) @(negedge i_clk);
    lp = 1'b1;
    repeat (4) @(negedge i_clk);
    `CHECK(arr_hv | arr_prog | arr_erase | arr_mass, 1'b0, "array controls in standby")
    `CHECK(flash_bus_if_i.ctl_status, 4'h0, "control bits after abort")
    repeat (20) @(negedge i_clk);
    `CHECK(arr_hv | arr_prog, 1'b0, "standby held")
    lp = 1'b0;
    $display("low power test done");
    wrap_up();
  end
endmodule : flash_program_protect_ctrl_tb
